/* File: inc/dsos_defines.svh */
`ifndef DSOS_DEFINES_SVH
`define DSOS_DEFINES_SVH

// register byte offsets
`define DSOS_ADDR_SEL      8'h00
`define DSOS_ADDR_FDET     8'h04
`define DSOS_ADDR_MAXF     8'h08
`define DSOS_ADDR_THERM    8'h0c
`define DSOS_ADDR_OLOAD    8'h10
`define DSOS_ADDR_STAT     8'h14
`define DSOS_ADDR_CTRL     8'h18

// reset values
`define DSOS_RST_SEL       32'h0000_110c
`define DSOS_RST_FDET      32'h0064_012c
`define DSOS_RST_MAXF      32'h0000_0fa0
`define DSOS_RST_THERM     32'h0096_6400
`define DSOS_RST_OLOAD     32'h3cb4_0a96

// field positions
`define DSOS_F_TERM        4:0
`define DSOS_F_RELAY       12:8
`define DSOS_F_MASK        18:16
`define DSOS_F_RESTART     27:24
`define DSOS_F_LEVEL       15:0
`define DSOS_F_BW          31:16
`define DSOS_F_MAXF        15:0
`define DSOS_B_TH_EN       0
`define DSOS_B_COOL        1
`define DSOS_F_CONT        15:8
`define DSOS_F_ONEMIN      24:16
`define DSOS_F_WLVL        7:0
`define DSOS_F_WTIME       12:8
`define DSOS_B_OL_EN       13
`define DSOS_F_TLVL        23:16
`define DSOS_F_TTIME       29:24
`define DSOS_B_CLR         0

// legal setting ranges, frequency in 0.1 Hz, levels in percent
`define DSOS_SEL_MAX       5'h11
`define DSOS_FREQ_MAX      16'h0fa0
`define DSOS_WLVL_MIN      8'h1e
`define DSOS_WLVL_MAX      8'h96
`define DSOS_WTIME_MAX     5'h1e
`define DSOS_TLVL_MIN      8'h1e
`define DSOS_TLVL_MAX      8'hc8
`define DSOS_TTIME_MAX     6'h3c
`define DSOS_ONEMIN_MIN    9'h032
`define DSOS_ONEMIN_MAX    9'h1c2
`define DSOS_CONT_MIN      8'h32
`define DSOS_CONT_MAX      8'h96

// protection thresholds
`define DSOS_OV_VOLTS      10'h190
`define DSOS_LV_VOLTS      10'h0c8
`define DSOS_DERATE_FREQ   16'h00c8
`define DSOS_THERM_WIN_S   8'h3c

// timing
`define DSOS_CLK_KHZ       40000
`define DSOS_SECOND_MS     1000
`define DSOS_SEC_CYCLES    (`DSOS_SECOND_MS * `DSOS_CLK_KHZ)

// axi responses
`define DSOS_RESP_OKAY     2'h0
`define DSOS_RESP_SLVERR   2'h2

`endif

/* File: inc/dsos_pkg.sv */
package dsos_pkg;

	// state flags reported by the drive core
	typedef struct packed {
		logic accelerating;
		logic decelerating;
		logic running;
		logic stopped;
		logic constant_run;
		logic waiting_run;
		logic heatsink_overheat_flag;
		logic command_lost;
		logic drive_overload_flag;
		logic stall;
		logic speed_search;
	} dsos_flags_t;

	// sampled drive quantities
	typedef struct packed {
		logic [15:0] run_freq;
		logic [15:0] set_freq;
		logic [9:0]  current;
		logic [9:0]  dc_volt;
	} dsos_sample_t;

	// latched trips
	typedef struct packed {
		logic ov;
		logic lv;
		logic oh;
		logic ol;
		logic thermal;
	} dsos_trip_t;

endpackage

/* File: design/dsos_top.sv */
// Notes on behaviour
// - code 2: output on while |level - run freq| is at most half bandwidth
// - code 3: on at level when accelerating; held above level-bw/2 when decelerating
// - code 4: same detection as code 3 with inverted polarity
// - code 8: output on after dc link above 400 V caused over-voltage trip
// - code 9: output on after dc link fell to 200 V causing low-voltage trip
// - code 10: output on when heatsink overheat protection has tripped
// - code 11: output on while frequency command is lost
// - code 12: output on while run command present and output voltage produced
// - code 13 on while stopped; code 14 on at constant speed
// - code 16: output on while waiting for external run command
// - code 17: output follows fault relay mask, e.g. 2 excludes low-voltage trips
// - mask bit0 low-voltage trip, bit1 other trips, bit2 restart count configured
// - selections take 0..17, defaults 12 terminal and 17 relay
// - level and bandwidth 0..400 Hz, defaults 30 and 10, not above max
// - code 5: current above warning level 30..150 percent, default 150
// - overload trip: current above 30..200 percent for trip time turns output off
// - thermal: time-inverse estimate above one-minute level turns output off
// - continuous level 50..150 never above one-minute level
// - cooling type 0 derates at low speed, 1 is speed independent
`timescale 1ns/1ps
`default_nettype none
`include "dsos_defines.svh"

module dsos_top #(
	parameter int SEC_CYCLES = `DSOS_SEC_CYCLES
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output var  logic                  awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output var  logic                  wready,
	// axi4-lite write response
	output var  logic [1:0]            bresp,
	output var  logic                  bvalid,
	input  wire logic                  bready,
	// axi4-lite read
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output var  logic                  arready,
	output var  logic [31:0]           rdata,
	output var  logic [1:0]            rresp,
	output var  logic                  rvalid,
	input  wire logic                  rready,
	// drive core
	input  wire logic                  ctrl_tick,
	input  wire dsos_pkg::dsos_sample_t core_sample,
	input  wire dsos_pkg::dsos_flags_t  core_flags,
	// outputs
	output var  logic                  multifunction_terminal,
	output var  logic                  multifunction_relay,
	output var  logic                  output_off,
	output var  logic                  overload_warning_flag
);

	logic [31:0]            reg_sel;
	logic [31:0]            reg_fdet;
	logic [31:0]            reg_maxf;
	logic [31:0]            reg_therm;
	logic [31:0]            reg_oload;
	logic                   aw_full;
	logic                   w_full;
	logic [7:0]             aw_addr;
	logic [31:0]            w_data;
	logic [3:0]             w_strb;
	logic                   commit;
	logic [31:0]            wmask;
	logic [31:0]            old_val;
	logic [31:0]            new_val;
	logic                   wr_ok;
	logic                   trip_clear;
	dsos_pkg::dsos_sample_t smp;
	dsos_pkg::dsos_flags_t  flg;
	dsos_pkg::dsos_trip_t   trip;
	logic                   fdt4;
	logic [17:0]            cond;
	logic [25:0]            sec_cnt;
	logic                   sec_pulse;
	logic [4:0]             warn_cnt;
	logic [5:0]             trip_cnt;
	logic [25:0]            heat_acc;
	logic signed [17:0]     d_lvl;
	logic signed [17:0]     d_set;
	logic [15:0]            abs_lvl;
	logic [15:0]            abs_set;
	logic [15:0]            half_bw;
	logic                   fdt1;
	logic                   fdt3;
	logic [7:0]             eff_cont;
	logic [19:0]            cur_sq;
	logic [19:0]            cont_sq;
	logic [25:0]            heat_limit;
	logic                   any_trip;
	logic                   fault_out;

	// write channels are taken independently, committed once both are held
	assign commit = aw_full && w_full && !bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
		end else if (awvalid && awready) begin
			awready <= 1'b0;
			aw_full <= 1'b1;
			aw_addr <= awaddr;
		end else if (commit) begin
			aw_full <= 1'b0;
		end else if (bvalid && bready) begin
			awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready <= 1'b1;
			w_full <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (wvalid && wready) begin
			wready <= 1'b0;
			w_full <= 1'b1;
			w_data <= wdata;
			w_strb <= wstrb;
		end else if (commit) begin
			w_full <= 1'b0;
		end else if (bvalid && bready) begin
			wready <= 1'b1;
		end
	end

	// byte-lane merge and range check; an illegal value is refused whole
	always_comb begin
		wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
		old_val = 32'h0000_0000;
		wr_ok = 1'b0;
		if (aw_addr == `DSOS_ADDR_SEL) begin
			old_val = reg_sel;
		end else if (aw_addr == `DSOS_ADDR_FDET) begin
			old_val = reg_fdet;
		end else if (aw_addr == `DSOS_ADDR_MAXF) begin
			old_val = reg_maxf;
		end else if (aw_addr == `DSOS_ADDR_THERM) begin
			old_val = reg_therm;
		end else if (aw_addr == `DSOS_ADDR_OLOAD) begin
			old_val = reg_oload;
		end
		new_val = (old_val & ~wmask) | (w_data & wmask);
		if (aw_addr == `DSOS_ADDR_SEL) begin
			wr_ok = (new_val[`DSOS_F_TERM] <= `DSOS_SEL_MAX) &&
				(new_val[`DSOS_F_RELAY] <= `DSOS_SEL_MAX);
		end else if (aw_addr == `DSOS_ADDR_FDET) begin
			wr_ok = (new_val[`DSOS_F_LEVEL] <= reg_maxf[`DSOS_F_MAXF]) &&
				(new_val[`DSOS_F_BW] <= reg_maxf[`DSOS_F_MAXF]);
		end else if (aw_addr == `DSOS_ADDR_MAXF) begin
			// lowering the ceiling below a held level would break that level
			wr_ok = (new_val[`DSOS_F_MAXF] <= `DSOS_FREQ_MAX) &&
				(new_val[`DSOS_F_MAXF] >= reg_fdet[`DSOS_F_LEVEL]) &&
				(new_val[`DSOS_F_MAXF] >= reg_fdet[`DSOS_F_BW]);
		end else if (aw_addr == `DSOS_ADDR_THERM) begin
			wr_ok = (new_val[`DSOS_F_ONEMIN] >= `DSOS_ONEMIN_MIN) &&
				(new_val[`DSOS_F_ONEMIN] <= `DSOS_ONEMIN_MAX) &&
				(new_val[`DSOS_F_CONT] >= `DSOS_CONT_MIN) &&
				(new_val[`DSOS_F_CONT] <= `DSOS_CONT_MAX) &&
				({1'b0, new_val[`DSOS_F_CONT]} <= new_val[`DSOS_F_ONEMIN]);
		end else if (aw_addr == `DSOS_ADDR_OLOAD) begin
			wr_ok = (new_val[`DSOS_F_WLVL] >= `DSOS_WLVL_MIN) &&
				(new_val[`DSOS_F_WLVL] <= `DSOS_WLVL_MAX) &&
				(new_val[`DSOS_F_WTIME] <= `DSOS_WTIME_MAX) &&
				(new_val[`DSOS_F_TLVL] >= `DSOS_TLVL_MIN) &&
				(new_val[`DSOS_F_TLVL] <= `DSOS_TLVL_MAX) &&
				(new_val[`DSOS_F_TTIME] <= `DSOS_TTIME_MAX);
		end else if (aw_addr == `DSOS_ADDR_CTRL) begin
			wr_ok = 1'b1;
		end
	end

	// configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reg_sel   <= `DSOS_RST_SEL;
			reg_fdet  <= `DSOS_RST_FDET;
			reg_maxf  <= `DSOS_RST_MAXF;
			reg_therm <= `DSOS_RST_THERM;
			reg_oload <= `DSOS_RST_OLOAD;
		end else if (commit && wr_ok) begin
			if (aw_addr == `DSOS_ADDR_SEL) begin
				reg_sel <= new_val & 32'h0f07_1f1f;
			end else if (aw_addr == `DSOS_ADDR_FDET) begin
				reg_fdet <= new_val;
			end else if (aw_addr == `DSOS_ADDR_MAXF) begin
				reg_maxf <= new_val & 32'h0000_ffff;
			end else if (aw_addr == `DSOS_ADDR_THERM) begin
				reg_therm <= new_val & 32'h01ff_ff03;
			end else if (aw_addr == `DSOS_ADDR_OLOAD) begin
				reg_oload <= new_val & 32'h3fff_3fff;
			end
		end
	end

	// write response one cycle after both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid     <= 1'b0;
			bresp      <= `DSOS_RESP_OKAY;
			trip_clear <= 1'b0;
		end else begin
			trip_clear <= commit && wr_ok && (aw_addr == `DSOS_ADDR_CTRL) &&
				w_strb[0] && w_data[`DSOS_B_CLR];
			if (commit) begin
				bvalid <= 1'b1;
				bresp  <= wr_ok ? `DSOS_RESP_OKAY : `DSOS_RESP_SLVERR;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= `DSOS_RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= `DSOS_RESP_OKAY;
			if (araddr == `DSOS_ADDR_SEL) begin
				rdata <= reg_sel;
			end else if (araddr == `DSOS_ADDR_FDET) begin
				rdata <= reg_fdet;
			end else if (araddr == `DSOS_ADDR_MAXF) begin
				rdata <= reg_maxf;
			end else if (araddr == `DSOS_ADDR_THERM) begin
				rdata <= reg_therm;
			end else if (araddr == `DSOS_ADDR_OLOAD) begin
				rdata <= reg_oload;
			end else if (araddr == `DSOS_ADDR_STAT) begin
				rdata <= {5'h00, multifunction_relay, multifunction_terminal, trip,
					2'h0, cond};
			end else if (araddr == `DSOS_ADDR_CTRL) begin
				rdata <= 32'h0000_0000;
			end else begin
				rdata <= 32'h0000_0000;
				rresp <= `DSOS_RESP_SLVERR;
			end
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	// sample the core only on its tick so every condition sees one snapshot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			smp <= '0;
			flg <= '0;
		end else if (ctrl_tick) begin
			smp <= core_sample;
			flg <= core_flags;
		end
	end

	// frequency detection arithmetic, all in 0.1 Hz
	always_comb begin
		half_bw = {1'b0, reg_fdet[31:17]};
		d_lvl   = $signed({2'b00, reg_fdet[`DSOS_F_LEVEL]}) - $signed({2'b00, smp.run_freq});
		d_set   = $signed({2'b00, smp.set_freq}) - $signed({2'b00, smp.run_freq});
		abs_lvl = d_lvl[17] ? 16'(-d_lvl) : d_lvl[15:0];
		abs_set = d_set[17] ? 16'(-d_set) : d_set[15:0];
		fdt3    = abs_lvl <= half_bw;
		fdt1    = abs_set <= half_bw;
	end

	// hysteretic detector: level on the way up, level minus half band on the way down
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fdt4 <= 1'b0;
		end else if (flg.accelerating) begin
			fdt4 <= smp.run_freq >= reg_fdet[`DSOS_F_LEVEL];
		end else if (flg.decelerating) begin
			fdt4 <= $signed({2'b00, smp.run_freq}) >
				$signed({2'b00, reg_fdet[`DSOS_F_LEVEL]}) - $signed({2'b00, half_bw});
		end
	end

	// one-second time base for warning, trip and thermal timers
	assign sec_pulse = sec_cnt == 26'(SEC_CYCLES - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sec_cnt <= 26'h000_0000;
		end else if (sec_pulse) begin
			sec_cnt <= 26'h000_0000;
		end else begin
			sec_cnt <= sec_cnt + 26'h000_0001;
		end
	end

	// overload warning: current above level for the warning time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_cnt              <= 5'h00;
			overload_warning_flag <= 1'b0;
		end else if (smp.current <= {2'h0, reg_oload[`DSOS_F_WLVL]}) begin
			warn_cnt              <= 5'h00;
			overload_warning_flag <= 1'b0;
		end else begin
			if (sec_pulse && warn_cnt != 5'h1f) begin
				warn_cnt <= warn_cnt + 5'h01;
			end
			overload_warning_flag <= warn_cnt >= reg_oload[`DSOS_F_WTIME];
		end
	end

	// overload trip timer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip_cnt <= 6'h00;
		end else if (!reg_oload[`DSOS_B_OL_EN] ||
				smp.current <= {2'h0, reg_oload[`DSOS_F_TLVL]}) begin
			trip_cnt <= 6'h00;
		end else if (sec_pulse && trip_cnt != 6'h3f) begin
			trip_cnt <= trip_cnt + 6'h01;
		end
	end

	// thermal model: heat grows with i^2 - ic^2, limit is one minute at the 1-min level
	always_comb begin
		eff_cont = reg_therm[`DSOS_F_CONT];
		if (!reg_therm[`DSOS_B_COOL] && smp.run_freq < `DSOS_DERATE_FREQ) begin
			// shaft fan loses airflow at low speed, so allow only three quarters
			eff_cont = reg_therm[`DSOS_F_CONT] - {2'h0, reg_therm[15:10]};
		end
		cur_sq     = smp.current * smp.current;
		cont_sq    = 20'(eff_cont * eff_cont);
		heat_limit = 26'((reg_therm[`DSOS_F_ONEMIN] * reg_therm[`DSOS_F_ONEMIN] -
			reg_therm[`DSOS_F_CONT] * reg_therm[`DSOS_F_CONT]) * `DSOS_THERM_WIN_S);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !reg_therm[`DSOS_B_TH_EN]) begin
			heat_acc <= 26'h000_0000;
		end else if (sec_pulse) begin
			if (cur_sq > cont_sq) begin
				heat_acc <= (heat_acc > 26'h3ff_ffff - {6'h00, cur_sq - cont_sq}) ?
					26'h3ff_ffff : heat_acc + {6'h00, cur_sq - cont_sq};
			end else if (heat_acc > {6'h00, cont_sq - cur_sq}) begin
				heat_acc <= heat_acc - {6'h00, cont_sq - cur_sq};
			end else begin
				heat_acc <= 26'h000_0000;
			end
		end
	end

	// sticky trips; a new trip in the clearing cycle survives the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trip <= '0;
		end else begin
			trip.ov <= (trip.ov && !trip_clear) || smp.dc_volt > `DSOS_OV_VOLTS;
			trip.lv <= (trip.lv && !trip_clear) || smp.dc_volt <= `DSOS_LV_VOLTS;
			trip.oh <= (trip.oh && !trip_clear) || flg.heatsink_overheat_flag;
			trip.ol <= (trip.ol && !trip_clear) || (reg_oload[`DSOS_B_OL_EN] &&
				trip_cnt >= reg_oload[`DSOS_F_TTIME] &&
				smp.current > {2'h0, reg_oload[`DSOS_F_TLVL]});
			trip.thermal <= (trip.thermal && !trip_clear) ||
				(reg_therm[`DSOS_B_TH_EN] && cur_sq > cont_sq &&
				heat_acc >= heat_limit);
		end
	end

	// fault relay mask decode
	always_comb begin
		any_trip  = |trip;
		fault_out = (reg_sel[16] && trip.lv) ||
			(reg_sel[17] && (trip.ov || trip.oh || trip.ol || trip.thermal)) ||
			(reg_sel[18] && reg_sel[`DSOS_F_RESTART] != 4'h0 && any_trip);
	end

	// condition vector indexed by selection code
	always_comb begin
		cond[0]  = fdt1;
		cond[1]  = fdt1 && smp.set_freq == reg_fdet[`DSOS_F_LEVEL];
		cond[2]  = fdt3;
		cond[3]  = fdt4;
		cond[4]  = !fdt4;
		cond[5]  = overload_warning_flag;
		cond[6]  = flg.drive_overload_flag;
		cond[7]  = flg.stall;
		cond[8]  = trip.ov;
		cond[9]  = trip.lv;
		cond[10] = trip.oh;
		cond[11] = flg.command_lost;
		cond[12] = flg.running;
		cond[13] = flg.stopped;
		cond[14] = flg.constant_run;
		cond[15] = flg.speed_search;
		cond[16] = flg.waiting_run;
		cond[17] = fault_out;
	end

	// outputs registered one edge after the conditions settle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			multifunction_terminal <= 1'b0;
			multifunction_relay    <= 1'b0;
			output_off             <= 1'b0;
		end else begin
			multifunction_terminal <= cond[reg_sel[`DSOS_F_TERM]];
			multifunction_relay    <= cond[reg_sel[`DSOS_F_RELAY]];
			output_off             <= any_trip;
		end
	end

endmodule

`default_nettype wire

/* File: testbench/dsos_props.sv */
`timescale 1ns/1ps
`default_nettype none

module dsos_props #(
	parameter int SEC_CYCLES = 10
) (
	// clock and reset
	input wire logic                   aclk,
	input wire logic                   aresetn,
	// register bus
	input wire logic [7:0]             awaddr,
	input wire logic                   awvalid,
	input wire logic                   awready,
	input wire logic [31:0]            wdata,
	input wire logic [3:0]             wstrb,
	input wire logic                   wvalid,
	input wire logic                   wready,
	input wire logic [1:0]             bresp,
	input wire logic                   bvalid,
	input wire logic                   bready,
	input wire logic                   arvalid,
	input wire logic                   arready,
	input wire logic [31:0]            rdata,
	input wire logic                   rvalid,
	input wire logic                   rready,
	// core side and outputs
	input wire logic                   ctrl_tick,
	input wire dsos_pkg::dsos_sample_t core_sample,
	input wire logic                   multifunction_relay,
	input wire logic                   output_off,
	input wire logic                   overload_warning_flag
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// write answered one commit cycle after both halves land
	AST_WRITE_ANSWER:
		assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	// terminal code above 17 refused whole
	AST_RANGE_REFUSED:
		assert property (awvalid && awready && wvalid && wready && awaddr == 8'h00
			&& wstrb == 4'hf && wdata[4:0] > 5'h11 |-> ##2 bvalid && bresp == 2'h2)
		else $error("bad selection not refused");
	AST_READ_ANSWER:
		assert property (arvalid && arready |=> rvalid && !arready)
		else $error("read answer late");
	AST_READ_HOLD:
		assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	// trips show on output_off three edges after the tick
	AST_OV_TRIP:
		assert property (ctrl_tick && core_sample.dc_volt > 10'h190 |-> ##3 output_off)
		else $error("over-voltage trip missed");
	AST_LV_TRIP:
		assert property (ctrl_tick && core_sample.dc_volt <= 10'h0c8 |-> ##3 output_off)
		else $error("low-voltage trip missed");
	// only a register write may release a trip
	AST_OFF_STICKY:
		assert property ($fell(output_off) |-> $past(bvalid) || $past(bvalid, 2))
		else $error("trip released without clear");
	// no level below 30 percent exists, so such current never warns
	AST_WARN_LOW:
		assert property (ctrl_tick && core_sample.current <= 10'h01e |-> ##2 !overload_warning_flag)
		else $error("warning with low current");

	cover property (output_off && multifunction_relay);
	cover property (overload_warning_flag);
	cover property (bvalid && bresp == 2'h2);
endmodule

`default_nettype wire

/* File: testbench/dsos_core_model.sv */
`timescale 1ns/1ps
`default_nettype none

module dsos_core_model (
	// clock, reset and pacing
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire logic                   slow,
	// values the core should report
	input  wire dsos_pkg::dsos_sample_t want_s,
	input  wire dsos_pkg::dsos_flags_t  want_f,
	// core side of the block
	output logic                        ctrl_tick,
	output dsos_pkg::dsos_sample_t      core_sample,
	output dsos_pkg::dsos_flags_t       core_flags
);
	logic [3:0] cnt;

	// tick every 2 or 8 cycles, quiet in reset
	always_ff @(posedge aclk) begin
		if (!aresetn || cnt == (slow ? 4'h7 : 4'h1)) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	assign ctrl_tick = aresetn && cnt == 4'h0;
	// levels held steady so a tick never sees half a sample
	assign core_sample = want_s;
	assign core_flags = want_f;
endmodule

`default_nettype wire

/* File: testbench/drive_status_output_select_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsos_defines.svh"

module drive_status_output_select_tb;
	logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, snap = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, rnd = 8'h28;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tick, term, relay, off, warn;
	logic [1:0] bresp, rresp;
	logic [15:0] f;
	dsos_pkg::dsos_sample_t want_s = {16'h0, 16'h0, 10'h0, 10'h12c}, core_sample;
	dsos_pkg::dsos_flags_t want_f = '0, core_flags;
	logic [33:0] exp_q[$];
	int mismatches = 0, n_checks = 0, cycles = 0;
	// selection table: code, run frequency, flags, expected terminal
	logic [4:0] tc [12] = '{5'h03, 5'h03, 5'h03, 5'h03, 5'h04, 5'h04,
		5'h0b, 5'h0c, 5'h0c, 5'h0d, 5'h0e, 5'h10};
	logic [15:0] tf [6] = '{16'h012c, 16'h012b, 16'h00fb, 16'h00fa, 16'h012c, 16'h012b};
	logic [10:0] tg [12] = '{11'h400, 11'h400, 11'h200, 11'h200, 11'h400, 11'h400,
		11'h008, 11'h100, 11'h080, 11'h080, 11'h040, 11'h020};
	logic [11:0] tx = 12'hee5;
	// trip table: code, dc volts, mask, expected relay
	logic [4:0] pc [5] = '{5'h08, 5'h09, 5'h09, 5'h0a, 5'h09};
	logic [9:0] pv [5] = '{10'h1c2, 10'h096, 10'h096, 10'h12c, 10'h096};
	logic [2:0] pm [5] = '{3'h2, 3'h2, 3'h1, 3'h2, 3'h4};
	logic [4:0] prx = 5'h1d;

	always #12.5 aclk = ~aclk;

	dsos_top #(.SEC_CYCLES(10)) i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .ctrl_tick(tick), .core_sample(core_sample),
		.core_flags(core_flags), .multifunction_terminal(term), .multifunction_relay(relay),
		.output_off(off), .overload_warning_flag(warn));

	dsos_core_model i_core (.aclk(aclk), .aresetn(aresetn), .slow(slow), .want_s(want_s),
		.want_f(want_f), .ctrl_tick(tick), .core_sample(core_sample), .core_flags(core_flags));

	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	// selection word, relay fixed on code 17
	function automatic logic [31:0] sel(input logic [4:0] t, input logic [2:0] m);
		return {7'h0, m[2], 5'h0, m, 3'h0, 5'h11, 3'h0, t};
	endfunction

	task automatic end_of_test();
		if (mismatches == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic cmp(input logic [33:0] got);
		logic [33:0] e;
		e = exp_q.pop_front();
		n_checks++;
		if (got !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		exp_q.push_back({r, 32'h0});
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
	endtask

	// rready offered with the address and held until rvalid is seen
	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		@(posedge aclk);
		exp_q.push_back({r, d});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
	endtask

	task automatic drive(input logic [15:0] q, input logic [9:0] c, v, input logic [10:0] g);
		@(posedge aclk);
		want_s <= {q, q, c, v};
		want_f <= dsos_pkg::dsos_flags_t'(g);
	endtask

	// outputs as {off, relay, terminal, warning}
	task automatic chk(input logic [3:0] e, input int w);
		repeat (w) @(posedge aclk);
		exp_q.push_back({30'h0, e});
		snap <= 1'b1;
		@(posedge aclk);
		snap <= 1'b0;
	endtask

	task automatic clear();
		drive(16'h012c, 10'h0, 10'h12c, 11'h0);
		repeat (12) @(posedge aclk);
		wr(`DSOS_ADDR_CTRL, 32'h1, `DSOS_RESP_OKAY);
	endtask

	// result watcher
	always @(posedge aclk) begin
		if (rvalid && rready) cmp({rresp, rdata});
		if (bvalid && bready) cmp({bresp, 32'h0});
		if (snap) cmp({30'h0, off, relay, term, warn});
	end

	// hang guard
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	initial begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		clear(); // zero sample before the first tick may trip low voltage
		chk(4'h0, 8);
		rd(`DSOS_ADDR_SEL, `DSOS_RST_SEL, `DSOS_RESP_OKAY);
		rd(`DSOS_ADDR_FDET, `DSOS_RST_FDET, `DSOS_RESP_OKAY);
		rd(`DSOS_ADDR_MAXF, `DSOS_RST_MAXF, `DSOS_RESP_OKAY);
		rd(`DSOS_ADDR_THERM, `DSOS_RST_THERM, `DSOS_RESP_OKAY);
		rd(`DSOS_ADDR_OLOAD, `DSOS_RST_OLOAD, `DSOS_RESP_OKAY);
		rd(8'h1c, 32'h0, `DSOS_RESP_SLVERR);
		wr(`DSOS_ADDR_SEL, sel(5'h12, 3'h0), `DSOS_RESP_SLVERR);
		wr(`DSOS_ADDR_FDET, 32'h0fa1_012c, `DSOS_RESP_SLVERR);
		wr(`DSOS_ADDR_MAXF, 32'h0000_0100, `DSOS_RESP_SLVERR);
		wr(`DSOS_ADDR_THERM, 32'h0064_7800, `DSOS_RESP_SLVERR);
		wr(`DSOS_ADDR_OLOAD, 32'h3cb4_0a1d, `DSOS_RESP_SLVERR);
		rd(`DSOS_ADDR_SEL, `DSOS_RST_SEL, `DSOS_RESP_OKAY);
		// band detection around 30 Hz with random run frequency
		wr(`DSOS_ADDR_SEL, sel(5'h02, 3'h0), `DSOS_RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			rnd = nxt(rnd);
			f = 16'h00fa + {9'h0, rnd[6:0]};
			drive(f, 10'h0, 10'h12c, 11'h0);
			chk({2'b00, f <= 16'h015e, 1'b0}, 16);
		end
		for (int i = 0; i < 12; i++) begin
			wr(`DSOS_ADDR_SEL, sel(tc[i], 3'h0), `DSOS_RESP_OKAY);
			drive(i < 6 ? tf[i] : 16'h012c, 10'h0, 10'h12c, tg[i]);
			chk({2'b00, tx[i], 1'b0}, 16);
		end
		for (int i = 0; i < 5; i++) begin
			wr(`DSOS_ADDR_SEL, sel(pc[i], pm[i]), `DSOS_RESP_OKAY);
			drive(16'h012c, 10'h0, pv[i], pc[i] == 5'h0a ? 11'h010 : 11'h0);
			chk({1'b1, prx[i], 2'b10}, 16);
			clear();
			chk(4'h0, 8);
		end
		// overload warning, then trip, both with zero time
		wr(`DSOS_ADDR_OLOAD, 32'h00b4_2096, `DSOS_RESP_OKAY);
		wr(`DSOS_ADDR_SEL, sel(5'h05, 3'h2), `DSOS_RESP_OKAY);
		drive(16'h012c, 10'h0a0, 10'h12c, 11'h0);
		chk(4'h3, 40);
		drive(16'h012c, 10'h0be, 10'h12c, 11'h0);
		chk(4'hf, 40);
		clear();
		// thermal at 300 percent trips in about ten seconds, warning needs thirty
		wr(`DSOS_ADDR_OLOAD, 32'h00b4_1e96, `DSOS_RESP_OKAY);
		wr(`DSOS_ADDR_THERM, 32'h0096_6403, `DSOS_RESP_OKAY);
		wr(`DSOS_ADDR_SEL, sel(5'h0c, 3'h2), `DSOS_RESP_OKAY);
		slow <= 1'b1;
		drive(16'h012c, 10'h12c, 10'h12c, 11'h0);
		chk(4'hc, 200);
		repeat (2) @(posedge aclk);
		end_of_test();
	end
endmodule

bind dsos_top dsos_props #(.SEC_CYCLES(SEC_CYCLES)) i_props (.aclk(aclk), .aresetn(aresetn),
	.awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
	.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
	.arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
	.ctrl_tick(ctrl_tick), .core_sample(core_sample), .multifunction_relay(multifunction_relay),
	.output_off(output_off), .overload_warning_flag(overload_warning_flag));

`default_nettype wire
